/* File: shared/rmc_consts.svh */
// Contract
// - Pin port: six pin bits, reset zero
// - Direction bit one drives pin, zero input
// - Sleep strobe enters sleep, clears itself
// - Nine-bit wake count split over two registers
// - Hold bit keeps radio machine in reset
// - Transmit bit forces radio transmit state
// - Receive bit forces radio receive state
// - Decrypt strobe runs until engine reports done
// - Encrypt strobe runs until engine reports done
// - Slot two suite select, default none
// - Slot one suite select, default none
// - Rate bit selects high or standard rate
// - Invert bit flips received symbol sign
// - Assess method and sense level field layout
// - Method codes 11, 10, 01; 00 reserved
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH

// ==========================================
// Register indices (byte address = 4 * index)
`define RMC_IDX_PIN_LEVEL      8'h33
`define RMC_IDX_PIN_DIR        8'h34
`define RMC_IDX_SLEEP_WAKE     8'h35
`define RMC_IDX_RADIO_MODE     8'h36
`define RMC_IDX_SEC_CTRL2      8'h37
`define RMC_IDX_BB_RATE        8'h38
`define RMC_IDX_BB_INVERT      8'h39
`define RMC_IDX_BB_ASSESS      8'h3a

// ==========================================
// Field layout
`define RMC_PIN_COUNT          6
`define RMC_SLEEP_BIT          7
`define RMC_WAKE_HI_LSB        3
`define RMC_HOLD_BIT           2
`define RMC_TX_BIT             1
`define RMC_RX_BIT             0
`define RMC_DEC_BIT            7
`define RMC_ENC_BIT            6
`define RMC_SLOT2_LSB          3
`define RMC_SLOT1_LSB          0
`define RMC_TURBO_BIT          0
`define RMC_INVERT_BIT         2
`define RMC_METHOD_LSB         6
`define RMC_LEVEL_LSB          2
`define RMC_WAKE_WIDTH         9

// ==========================================
// Reset values
`define RMC_RST_PINS           6'h00
`define RMC_RST_WAKE           9'h000
`define RMC_RST_SUITE          3'h0
`define RMC_RST_METHOD         2'h1
`define RMC_RST_LEVEL          4'h2
`define RMC_METHOD_RESERVED    2'h0

`endif

/* File: shared/rmc_pkg.sv */
package rmc_pkg;

  typedef enum logic [1:0] {
    RMC_RS_HOLD,
    RMC_RS_IDLE,
    RMC_RS_TX,
    RMC_RS_RX
  } rmc_radio_state_t;

  typedef enum logic [2:0] {
    RMC_SUITE_NONE,
    RMC_SUITE_CTR,
    RMC_SUITE_CCM128,
    RMC_SUITE_CCM64,
    RMC_SUITE_CCM32,
    RMC_SUITE_MAC128,
    RMC_SUITE_MAC64,
    RMC_SUITE_MAC32
  } rmc_suite_t;

  typedef enum logic [1:0] {
    RMC_CCA_RSVD,
    RMC_CCA_CARRIER,
    RMC_CCA_ENERGY,
    RMC_CCA_BOTH
  } rmc_cca_method_t;

endpackage : rmc_pkg

/* File: design/rmc_pin_sync.sv */
`timescale 1ns/1ps
`include "rmc_consts.svh"

module rmc_pin_sync
  import rmc_pkg::*;
(
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic [`RMC_PIN_COUNT-1:0]  pin_async,
  output logic      [`RMC_PIN_COUNT-1:0]  pin_synced
);

  // ==========================================
  // Two-stage synchroniser per pin
  logic [`RMC_PIN_COUNT-1:0] stage_one;

  for (genvar i = 0; i < `RMC_PIN_COUNT; i++) begin : g_pin
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stage_one[i]  <= 1'b0;
        pin_synced[i] <= 1'b0;
      end else begin
        stage_one[i]  <= pin_async[i];
        pin_synced[i] <= stage_one[i];
      end
    end
  end

endmodule : rmc_pin_sync

/* File: design/rmc_top.sv */
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rmc_consts.svh"

module rmc_top
  import rmc_pkg::*;
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  input  wire logic [`RMC_PIN_COUNT-1:0]     pin_level_in,
  output logic [`RMC_PIN_COUNT-1:0]          pin_level_out,
  output logic [`RMC_PIN_COUNT-1:0]          pin_level_oe,
  output logic                               sleep_entry_strobe,
  output logic [`RMC_WAKE_WIDTH-1:0]         osc_startup_count,
  output logic                               radio_fsm_hold,
  output logic                               force_transmit_state,
  output logic                               force_receive_state,
  output rmc_radio_state_t                   radio_state,
  input  wire logic                          ul_sec_done,
  output logic                               upper_layer_decrypt_go,
  output logic                               upper_layer_encrypt_go,
  output rmc_suite_t                         slot2_suite_select,
  output rmc_suite_t                         slot1_suite_select,
  output logic                               turbo_rate_select,
  output logic                               symbol_sign_invert,
  output rmc_cca_method_t                    channel_assess_method,
  output logic [3:0]                         carrier_sense_level
);

  // ==========================================
  // Bus address phase capture
  logic        addr_take;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  acc_idx;
  logic        acc_aligned;
  logic [7:0]  wdata;
  logic [7:0]  rd_value;
  logic [`RMC_PIN_COUNT-1:0] pin_synced;
  logic [`RMC_PIN_COUNT-1:0] pin_direction_bit;

  // hsize is not decoded: only whole-word transfers are issued
  assign addr_take = hsel && htrans[1] && hready;
  assign wdata     = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      acc_idx     <= 8'h00;
      acc_aligned <= 1'b0;
    end else begin
      if (hready) begin
        wr_pend <= addr_take && hwrite;
      end
      if (addr_take && !hwrite) begin
        rd_pend <= 1'b1;
      end else if (rd_pend && !hreadyout) begin
        rd_pend <= 1'b0;
      end
      if (addr_take) begin
        acc_idx     <= haddr[9:2];
        acc_aligned <= (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);
      end
    end
  end

  // Write data lands in the data phase; reads wait one cycle so a read that
  // follows a write always sees the committed value
  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_pend && acc_aligned && (acc_idx == idx);
  endfunction : wr_hit

  // ==========================================
  // Bus response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (addr_take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend && !hreadyout) begin
        hreadyout <= 1'b1;
        hrdata    <= {24'h00_0000, rd_value};
      end else begin
        hreadyout <= 1'b1;
      end
    end
  end

  // ==========================================
  // Pin port and direction
  rmc_pin_sync u_pin_sync (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_async  (pin_level_in),
    .pin_synced (pin_synced)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level_out     <= `RMC_RST_PINS;
      pin_direction_bit <= `RMC_RST_PINS;
      pin_level_oe      <= `RMC_RST_PINS;
    end else begin
      if (wr_hit(`RMC_IDX_PIN_LEVEL)) begin
        pin_level_out <= wdata[`RMC_PIN_COUNT-1:0];
      end
      if (wr_hit(`RMC_IDX_PIN_DIR)) begin
        pin_direction_bit <= wdata[`RMC_PIN_COUNT-1:0];
        pin_level_oe      <= wdata[`RMC_PIN_COUNT-1:0];
      end
    end
  end

  // ==========================================
  // Sleep strobe and wake count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_entry_strobe <= 1'b0;
    end else begin
      sleep_entry_strobe <= wr_hit(`RMC_IDX_SLEEP_WAKE) && wdata[`RMC_SLEEP_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_startup_count <= `RMC_RST_WAKE;
    end else begin
      if (wr_hit(`RMC_IDX_SLEEP_WAKE)) begin
        osc_startup_count[6:0] <= wdata[6:0];
      end
      if (wr_hit(`RMC_IDX_RADIO_MODE)) begin
        osc_startup_count[8:7] <= wdata[`RMC_WAKE_HI_LSB+:2];
      end
    end
  end

  // ==========================================
  // Radio mode control and radio state machine
  rmc_radio_state_t next_radio_state;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_fsm_hold       <= 1'b0;
      force_transmit_state <= 1'b0;
      force_receive_state  <= 1'b0;
    end else if (wr_hit(`RMC_IDX_RADIO_MODE)) begin
      radio_fsm_hold       <= wdata[`RMC_HOLD_BIT];
      force_transmit_state <= wdata[`RMC_TX_BIT];
      force_receive_state  <= wdata[`RMC_RX_BIT];
    end
  end

  // Transmit wins when both force bits are set
  always_comb begin
    next_radio_state = radio_state;
    case (radio_state)
      RMC_RS_HOLD, RMC_RS_IDLE, RMC_RS_TX, RMC_RS_RX: begin
        if (radio_fsm_hold) begin
          next_radio_state = RMC_RS_HOLD;
        end else if (force_transmit_state) begin
          next_radio_state = RMC_RS_TX;
        end else if (force_receive_state) begin
          next_radio_state = RMC_RS_RX;
        end else begin
          next_radio_state = RMC_RS_IDLE;
        end
      end
      default: begin
        next_radio_state = RMC_RS_HOLD;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_state <= RMC_RS_IDLE;
    end else begin
      radio_state <= next_radio_state;
    end
  end

  // ==========================================
  // Upper-layer security strobes and slot suites
  logic dec_set;
  logic enc_set;

  assign dec_set = wr_hit(`RMC_IDX_SEC_CTRL2) && wdata[`RMC_DEC_BIT];
  assign enc_set = wr_hit(`RMC_IDX_SEC_CTRL2) && wdata[`RMC_ENC_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_layer_decrypt_go <= 1'b0;
      upper_layer_encrypt_go <= 1'b0;
    end else begin
      // decrypt held until done; set wins
      if (dec_set) begin
        upper_layer_decrypt_go <= 1'b1;
      end else if (ul_sec_done) begin
        upper_layer_decrypt_go <= 1'b0;
      end
      // encrypt held until done; set wins
      if (enc_set) begin
        upper_layer_encrypt_go <= 1'b1;
      end else if (ul_sec_done) begin
        upper_layer_encrypt_go <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot2_suite_select <= rmc_suite_t'(`RMC_RST_SUITE);
      slot1_suite_select <= rmc_suite_t'(`RMC_RST_SUITE);
    end else if (wr_hit(`RMC_IDX_SEC_CTRL2)) begin
      slot2_suite_select <= rmc_suite_t'(wdata[`RMC_SLOT2_LSB+:3]);
      slot1_suite_select <= rmc_suite_t'(wdata[`RMC_SLOT1_LSB+:3]);
    end
  end

  // ==========================================
  // Baseband controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      turbo_rate_select     <= 1'b0;
      symbol_sign_invert    <= 1'b0;
      channel_assess_method <= rmc_cca_method_t'(`RMC_RST_METHOD);
      carrier_sense_level   <= `RMC_RST_LEVEL;
    end else begin
      if (wr_hit(`RMC_IDX_BB_RATE)) begin
        turbo_rate_select <= wdata[`RMC_TURBO_BIT];
      end
      if (wr_hit(`RMC_IDX_BB_INVERT)) begin
        symbol_sign_invert <= wdata[`RMC_INVERT_BIT];
      end
      if (wr_hit(`RMC_IDX_BB_ASSESS)) begin
        if (wdata[`RMC_METHOD_LSB+:2] != `RMC_METHOD_RESERVED) begin
          channel_assess_method <= rmc_cca_method_t'(wdata[`RMC_METHOD_LSB+:2]);
        end
        carrier_sense_level <= wdata[`RMC_LEVEL_LSB+:4];
      end
    end
  end

  // ==========================================
  // Read mux
  always_comb begin
    rd_value = 8'h00;
    if (acc_aligned) begin
      // reserved bits and strobes read zero
      case (acc_idx)
        `RMC_IDX_PIN_LEVEL: begin
          for (int i = 0; i < `RMC_PIN_COUNT; i++) begin
            rd_value[i] = pin_direction_bit[i] ? pin_level_out[i] : pin_synced[i];
          end
        end
        `RMC_IDX_PIN_DIR:    rd_value = {2'h0, pin_direction_bit};
        `RMC_IDX_SLEEP_WAKE: rd_value = {1'b0, osc_startup_count[6:0]};
        `RMC_IDX_RADIO_MODE: rd_value = {3'h0, osc_startup_count[8:7], radio_fsm_hold,
                                         force_transmit_state, force_receive_state};
        `RMC_IDX_SEC_CTRL2:  rd_value = {2'h0, slot2_suite_select, slot1_suite_select};
        `RMC_IDX_BB_RATE:    rd_value = {7'h00, turbo_rate_select};
        `RMC_IDX_BB_INVERT:  rd_value = {5'h00, symbol_sign_invert, 2'h0};
        `RMC_IDX_BB_ASSESS:  rd_value = {channel_assess_method, carrier_sense_level, 2'h0};
        default:             rd_value = 8'h00;
      endcase
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_pin_out_write: assert property (
    wr_hit(`RMC_IDX_PIN_LEVEL) |=> pin_level_out == $past(hwdata[5:0])
  ) else $error("pin level latch did not take written value");

  chk_dir_enable: assert property (
    wr_hit(`RMC_IDX_PIN_DIR) |=> pin_level_oe == $past(hwdata[5:0])
  ) else $error("pin enable did not take written direction bits");

  chk_sleep_pulse: assert property (
    sleep_entry_strobe |=> !sleep_entry_strobe || $past(wr_hit(`RMC_IDX_SLEEP_WAKE))
  ) else $error("sleep strobe did not clear itself");

  chk_wake_high: assert property (
    wr_hit(`RMC_IDX_RADIO_MODE) |=> osc_startup_count[8:7] == $past(hwdata[4:3])
  ) else $error("wake count top bits not taken from mode register");

  chk_hold_state: assert property (
    radio_fsm_hold |=> radio_state == RMC_RS_HOLD
  ) else $error("radio machine left reset while hold set");

  chk_force_tx: assert property (
    !radio_fsm_hold && force_transmit_state |=> radio_state == RMC_RS_TX
  ) else $error("forced transmit not reached");

  chk_force_rx: assert property (
    !radio_fsm_hold && !force_transmit_state && force_receive_state |=> radio_state == RMC_RS_RX
  ) else $error("forced receive not reached");

  chk_enc_done: assert property (
    upper_layer_encrypt_go && ul_sec_done && !enc_set |=> !upper_layer_encrypt_go
  ) else $error("encrypt strobe not cleared on done");

  chk_dec_start: assert property (
    dec_set |=> upper_layer_decrypt_go
  ) else $error("decrypt strobe not raised on write");

  chk_method_rsvd: assert property (
    channel_assess_method != RMC_CCA_RSVD
  ) else $error("assessment method holds reserved code");

  chk_read_timing: assert property (
    addr_take && !hwrite |=> !hreadyout ##1 hreadyout
  ) else $error("read answer not on second data cycle");

endmodule : rmc_top

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "rmc_consts.svh"

module tb
  import rmc_pkg::*;
;
  logic                       hclk = 1'b0;
  logic                       hresetn;
  logic                       hsel;
  logic [31:0]                haddr;
  logic [1:0]                 htrans;
  logic                       hwrite;
  logic [2:0]                 hsize;
  logic [31:0]                hwdata;
  logic                       hready;
  logic                       hreadyout;
  logic                       hresp;
  logic [31:0]                hrdata;
  logic [`RMC_PIN_COUNT-1:0]  pin_level_in;
  logic [`RMC_PIN_COUNT-1:0]  pin_level_out;
  logic [`RMC_PIN_COUNT-1:0]  pin_level_oe;
  logic                       sleep_entry_strobe;
  logic [`RMC_WAKE_WIDTH-1:0] osc_startup_count;
  logic                       radio_fsm_hold;
  logic                       force_transmit_state;
  logic                       force_receive_state;
  rmc_radio_state_t           radio_state;
  logic                       ul_sec_done;
  logic                       upper_layer_decrypt_go;
  logic                       upper_layer_encrypt_go;
  rmc_suite_t                 slot2_suite_select;
  rmc_suite_t                 slot1_suite_select;
  logic                       turbo_rate_select;
  logic                       symbol_sign_invert;
  rmc_cca_method_t            channel_assess_method;
  logic [3:0]                 carrier_sense_level;
  logic [7:0]                 sh [8];
  logic [7:0]                 rf_seq [5] = '{8'h06, 8'h02, 8'h01, 8'h03, 8'h00};
  logic [7:0]                 sec_seq [3] = '{8'h80, 8'h40, 8'hc0};
  logic [31:0]                bad_addr [3] = '{32'h000000ec, 32'h000000cd, 32'h000004cc};
  logic [31:0]                rnd = 32'hecd3;
  logic [31:0]                rdat;
  int                         err_count = 0;
  int                         checks_done = 0;
  int                         cyc = 0;

  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  rmc_top uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pin_level_in, .pin_level_out, .pin_level_oe,
    .sleep_entry_strobe, .osc_startup_count, .radio_fsm_hold, .force_transmit_state,
    .force_receive_state, .radio_state, .ul_sec_done, .upper_layer_decrypt_go,
    .upper_layer_encrypt_go, .slot2_suite_select, .slot1_suite_select,
    .turbo_rate_select, .symbol_sign_invert, .channel_assess_method, .carrier_sense_level
  );

  // ==========================================
  // Reporting
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Generous ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ==========================================
  // Expectation model
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] next_shadow(input int i, input logic [7:0] o, input logic [7:0] d);
    case (i)
      0, 1, 4: return d & 8'h3f;
      2:       return d & 8'h7f;
      3:       return d & 8'h1f;
      5:       return d & 8'h01;
      6:       return d & 8'h04;
      // Method code 00 is refused, the old method stays
      default: return {(d[7:6] == 2'b00) ? o[7:6] : d[7:6], d[5:2], 2'b00};
    endcase
  endfunction : next_shadow

  function automatic logic [7:0] exp_rd(input int i);
    if (i == 0)
      return {2'b00, (sh[0][5:0] & sh[1][5:0]) | (pin_level_in & ~sh[1][5:0])};
    return sh[i];
  endfunction : exp_rd

  function automatic rmc_radio_state_t exp_state(input logic [7:0] c);
    if (c[2])
      return RMC_RS_HOLD;
    if (c[1])
      return RMC_RS_TX;
    if (c[0])
      return RMC_RS_RX;
    return RMC_RS_IDLE;
  endfunction : exp_state

  // ==========================================
  // Bus master; called just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : xfer

  task automatic wr(input int i, input logic [7:0] d);
    xfer(1'b1, ({24'h000000, `RMC_IDX_PIN_LEVEL} + 32'(i)) << 2, d, rdat);
    sh[i] = next_shadow(i, sh[i], d);
  endtask : wr

  task automatic rd(input int i);
    xfer(1'b0, ({24'h000000, `RMC_IDX_PIN_LEVEL} + 32'(i)) << 2, 8'h00, rdat);
    cmp(rdat, {24'h000000, exp_rd(i)});
  endtask : rd

  // Radio state lags the register by one cycle, hence one edge before the checks
  task automatic chk_outs();
    @(posedge hclk);
    #1;
    cmp(pin_level_out, sh[0][5:0]);
    cmp(pin_level_oe, sh[1][5:0]);
    cmp(osc_startup_count, {sh[3][4:3], sh[2][6:0]});
    cmp({radio_fsm_hold, force_transmit_state, force_receive_state}, sh[3][2:0]);
    cmp(radio_state, exp_state(sh[3]));
    cmp({slot2_suite_select, slot1_suite_select}, sh[4][5:0]);
    cmp({turbo_rate_select, symbol_sign_invert}, {sh[5][0], sh[6][2]});
    cmp({channel_assess_method, carrier_sense_level}, sh[7][7:2]);
    @(posedge hclk);
  endtask : chk_outs

  task automatic reset_chk();
    for (int i = 0; i < 8; i++) sh[i] = 8'h00;
    sh[7] = {2'b01, 4'b0010, 2'b00};
    chk_outs();
    for (int i = 0; i < 8; i++) rd(i);
  endtask : reset_chk

  // ==========================================
  // Main sequence
  initial begin
    int         i;
    logic [7:0] d;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    pin_level_in = 6'h00;
    ul_sec_done = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_chk();
    for (int k = 0; k < 8; k++) begin
      wr(k, 8'hff);
      rd(k);
    end
    chk_outs();
    // Both go bits stay set until the engine reports done
    cmp({upper_layer_decrypt_go, upper_layer_encrypt_go}, 2'b11);
    ul_sec_done <= 1'b1;
    @(posedge hclk);
    ul_sec_done <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 cmp({upper_layer_decrypt_go, upper_layer_encrypt_go}, 2'b00);
    @(posedge hclk);
    for (int k = 0; k < 5; k++) begin
      wr(3, rf_seq[k]);
      chk_outs();
    end
    wr(2, 8'h5f);
    wr(3, 8'h08);
    chk_outs();
    // Sleep pulse only when bit 7 is written as one
    for (int k = 1; k >= 0; k--) begin
      wr(2, {k[0], 7'h5f});
      #1 cmp(sleep_entry_strobe, k[0]);
      @(posedge hclk);
      #1 cmp(sleep_entry_strobe, 1'b0);
      @(posedge hclk);
      rd(2);
    end
    for (int k = 0; k < 3; k++) begin
      wr(4, sec_seq[k]);
      repeat (2) @(posedge hclk);
      #1 cmp({upper_layer_decrypt_go, upper_layer_encrypt_go}, sec_seq[k][7:6]);
      @(posedge hclk);
      ul_sec_done <= 1'b1;
      @(posedge hclk);
      ul_sec_done <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 cmp({upper_layer_decrypt_go, upper_layer_encrypt_go}, 2'b00);
      @(posedge hclk);
      rd(4);
    end
    for (int k = 0; k < 8; k++) begin
      wr(4, {2'b00, k[2:0], ~k[2:0]});
      chk_outs();
    end
    for (int k = 1; k < 4; k++) begin
      wr(7, {k[1:0], 4'b1110, 2'b11});
      chk_outs();
    end
    wr(7, 8'h08);
    chk_outs();
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, bad_addr[k], 8'hff, rdat);
      xfer(1'b0, bad_addr[k], 8'h00, rdat);
      cmp(rdat, 32'h00000000);
      cmp(hresp, 1'b0);
    end
    chk_outs();
    // Random traffic, write then read back to back
    repeat (150) begin
      rnd = lfsr(rnd);
      pin_level_in <= rnd[13:8];
      i = int'(rnd[2:0]);
      d = rnd[23:16];
      if (i == 7 && d[7:6] == 2'b00)
        d[7] = 1'b1;
      wr(i, d);
      rd(i);
      chk_outs();
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_chk();
    test_done();
  end
endmodule : tb
